/* src/edmi_pkg.sv */
// Purpose: constants, types and register map of the external data memory
//          interface
// Assumes: 100 MHz system clock, 8-bit register port
// Notes:   all layouts used by the main module and the xram live here

package edmi_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] EDMI_ADDR_TIMING = 8'ha1;
	localparam logic [7:0] EDMI_ADDR_PAGE = 8'ha2;
	localparam logic [7:0] EDMI_ADDR_CONFIG = 8'ha3;
	localparam logic [7:0] EDMI_ADDR_STATUS = 8'ha4;

	localparam logic [7:0] EDMI_RST_TIMING = 8'hff;
	localparam logic [7:0] EDMI_RST_PAGE = 8'h00;
	localparam logic [7:0] EDMI_RST_CONFIG = 8'h03;
	localparam logic [7:0] EDMI_CONFIG_MASK = 8'h3f;

	// ----------------------------------------------------------------
	// memory modes and sizes
	// ----------------------------------------------------------------
	localparam logic [1:0] EDMI_MODE_INT = 2'h0;
	localparam logic [1:0] EDMI_MODE_SPLIT = 2'h1;
	localparam logic [1:0] EDMI_MODE_BANK = 2'h2;
	localparam logic [1:0] EDMI_MODE_EXT = 2'h3;

	localparam int EDMI_XRAM_AW = 12;
	localparam int EDMI_XRAM_DEPTH = 4096;
	localparam logic [3:0] EDMI_ONCHIP_TOP = 4'h0;

	// ----------------------------------------------------------------
	// timing counts
	// ----------------------------------------------------------------
	localparam logic [3:0] EDMI_TAIL_LAST = 4'h2;
	localparam logic [3:0] EDMI_CNT_ZERO = 4'h0;
	localparam int EDMI_SYNC_CAPTURE = 1;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] setup;
		logic [3:0] width;
		logic [1:0] hold;
	} edmi_timing_t;

	typedef struct packed {
		logic [1:0] unused;
		logic port_en;
		logic mux_sel;
		logic [1:0] mode;
		logic [1:0] ale_w;
	} edmi_cfg_t;

	typedef struct packed {
		logic wide;
		logic write;
		logic [15:0] ptr;
		logic [7:0] idx;
		logic [7:0] wdata;
	} edmi_req_t;

	typedef enum logic [3:0] {
		EDMI_IDLE = 4'h0,
		EDMI_START = 4'h1,
		EDMI_ALEH = 4'h3,
		EDMI_ALEL = 4'h2,
		EDMI_SETUP = 4'h6,
		EDMI_STRB = 4'h7,
		EDMI_HOLD = 4'h5,
		EDMI_TAIL = 4'h4,
		EDMI_INT = 4'hc
	} edmi_state_t;

endpackage

/* src/edmi_xram.sv */
// Purpose: on-chip 4 kB xram with registered read data
// Assumes: single clock, one access per cycle
// Notes:   contents are not reset; only the read register is

module edmi_xram (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// access
	input wire logic en,
	input wire logic we,
	input wire logic [edmi_pkg::EDMI_XRAM_AW-1:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata_q
);

	logic [7:0] mem [edmi_pkg::EDMI_XRAM_DEPTH];

	always_ff @(posedge clk) begin
		if (en && we) begin
			mem[addr] <= wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 8'h00;
		end else if (en && !we) begin
			rdata_q <= mem[addr];
		end
	end

endmodule

/* src/edmi_top.sv */
// Purpose: steers external-move accesses to on-chip xram or off-chip memory
// Assumes: cpu request port on the system clock; data pins asynchronous
// Notes:   timing and config are snapshot when an access starts
//
// Local design decision: the strobed register port.

module edmi_top (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RESETN,
	// register port
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	// cpu access port
	input wire logic ACC_REQ,
	input wire logic ACC_WIDE,
	input wire logic ACC_WRITE,
	input wire logic [15:0] ACC_PTR,
	input wire logic [7:0] ACC_IDX,
	input wire logic [7:0] ACC_WDATA,
	output logic ACC_BUSY,
	output logic ACC_DONE,
	output logic [7:0] ACC_RDATA,
	// external memory pins
	output logic PIN_CLAIM,
	output logic PORT_EN,
	output logic [15:0] EXT_ADDR_O,
	output logic EXT_ADDR_HI_OE,
	output logic EXT_ADDR_LO_OE,
	input wire logic [7:0] EXT_DATA_I,
	output logic [7:0] EXT_DATA_O,
	output logic EXT_DATA_OE,
	output logic EXT_ALE,
	output logic EXT_RD_N,
	output logic EXT_WR_N
);

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	function automatic logic goes_onchip(input logic [1:0] mode,
			input logic [15:0] eff);
		case (mode)
			edmi_pkg::EDMI_MODE_INT: goes_onchip = 1'b1;
			edmi_pkg::EDMI_MODE_EXT: goes_onchip = 1'b0;
			default: goes_onchip = (eff[15:12] == edmi_pkg::EDMI_ONCHIP_TOP);
		endcase
	endfunction

	function automatic logic drives_hi(input logic [1:0] mode,
			input logic wide);
		drives_hi = wide || (mode == edmi_pkg::EDMI_MODE_BANK);
	endfunction

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0] timing_q;
	logic [7:0] page_q;
	logic [7:0] config_q;
	logic [7:0] reg_rdata_q;
	edmi_pkg::edmi_state_t state_q;
	edmi_pkg::edmi_state_t state_d;
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	edmi_pkg::edmi_req_t req_q;
	edmi_pkg::edmi_timing_t tim_q;
	edmi_pkg::edmi_cfg_t cfg_q;
	logic [15:0] addr_q;
	logic hi_oe_q;
	logic done_q;
	logic [7:0] rdata_q;
	logic [1:0] rd_pipe_q;
	logic [7:0] sync1_v_q;
	logic [7:0] sync2_q;
	logic [7:0] sync3_q;
	logic [7:0] ram_rdata;
	logic accept;
	logic onchip;
	logic [15:0] eff;
	edmi_pkg::edmi_cfg_t cfg_now;

	assign cfg_now = edmi_pkg::edmi_cfg_t'(config_q);
	assign accept = ACC_REQ && (state_q == edmi_pkg::EDMI_IDLE);
	assign eff = ACC_WIDE ? ACC_PTR : {page_q, ACC_IDX};
	assign onchip = goes_onchip(cfg_now.mode, eff);

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			timing_q <= edmi_pkg::EDMI_RST_TIMING;
			page_q <= edmi_pkg::EDMI_RST_PAGE;
			config_q <= edmi_pkg::EDMI_RST_CONFIG;
		end else if (REG_WR) begin
			case (REG_ADDR)
				edmi_pkg::EDMI_ADDR_TIMING: timing_q <= REG_WDATA;
				edmi_pkg::EDMI_ADDR_PAGE: page_q <= REG_WDATA;
				edmi_pkg::EDMI_ADDR_CONFIG: begin
					config_q <= REG_WDATA & edmi_pkg::EDMI_CONFIG_MASK;
				end
				default: ;
			endcase
		end
	end

	// unmapped reads answer zero
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			reg_rdata_q <= 8'h00;
		end else if (REG_RD) begin
			case (REG_ADDR)
				edmi_pkg::EDMI_ADDR_TIMING: reg_rdata_q <= timing_q;
				edmi_pkg::EDMI_ADDR_PAGE: reg_rdata_q <= page_q;
				edmi_pkg::EDMI_ADDR_CONFIG: reg_rdata_q <= config_q;
				edmi_pkg::EDMI_ADDR_STATUS: begin
					reg_rdata_q <= {6'h00, PIN_CLAIM, ACC_BUSY};
				end
				default: reg_rdata_q <= 8'h00;
			endcase
		end else begin
			reg_rdata_q <= 8'h00;
		end
	end

	assign REG_RDATA = reg_rdata_q;

	// ----------------------------------------------------------------
	// access snapshot
	// ----------------------------------------------------------------
	// a register write mid-access must not stretch a running phase
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			req_q <= '0;
			tim_q <= '0;
			cfg_q <= '0;
			addr_q <= 16'h0000;
			hi_oe_q <= 1'b0;
		end else if (accept) begin
			req_q <= {ACC_WIDE, ACC_WRITE, ACC_PTR, ACC_IDX, ACC_WDATA};
			tim_q <= edmi_pkg::edmi_timing_t'(timing_q);
			cfg_q <= cfg_now;
			addr_q <= eff;
			hi_oe_q <= drives_hi(cfg_now.mode, ACC_WIDE);
		end
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		cnt_d = (cnt_q == edmi_pkg::EDMI_CNT_ZERO) ? cnt_q : cnt_q - 4'h1;
		case (state_q)
			edmi_pkg::EDMI_IDLE: begin
				if (accept) begin
					state_d = onchip ? edmi_pkg::EDMI_INT :
						edmi_pkg::EDMI_START;
				end
			end
			edmi_pkg::EDMI_INT: state_d = edmi_pkg::EDMI_IDLE;
			edmi_pkg::EDMI_START: begin
				if (!cfg_q.mux_sel) begin
					state_d = edmi_pkg::EDMI_ALEH;
					cnt_d = {2'b00, cfg_q.ale_w};
				end else if (tim_q.setup != 2'b00) begin
					state_d = edmi_pkg::EDMI_SETUP;
					cnt_d = {2'b00, tim_q.setup} - 4'h1;
				end else begin
					state_d = edmi_pkg::EDMI_STRB;
					cnt_d = tim_q.width;
				end
			end
			edmi_pkg::EDMI_ALEH: begin
				if (cnt_q == edmi_pkg::EDMI_CNT_ZERO) begin
					state_d = edmi_pkg::EDMI_ALEL;
					cnt_d = {2'b00, cfg_q.ale_w};
				end
			end
			edmi_pkg::EDMI_ALEL: begin
				if (cnt_q == edmi_pkg::EDMI_CNT_ZERO) begin
					if (tim_q.setup != 2'b00) begin
						state_d = edmi_pkg::EDMI_SETUP;
						cnt_d = {2'b00, tim_q.setup} - 4'h1;
					end else begin
						state_d = edmi_pkg::EDMI_STRB;
						cnt_d = tim_q.width;
					end
				end
			end
			edmi_pkg::EDMI_SETUP: begin
				if (cnt_q == edmi_pkg::EDMI_CNT_ZERO) begin
					state_d = edmi_pkg::EDMI_STRB;
					cnt_d = tim_q.width;
				end
			end
			edmi_pkg::EDMI_STRB: begin
				if (cnt_q == edmi_pkg::EDMI_CNT_ZERO) begin
					if (tim_q.hold != 2'b00) begin
						state_d = edmi_pkg::EDMI_HOLD;
						cnt_d = {2'b00, tim_q.hold} - 4'h1;
					end else begin
						state_d = edmi_pkg::EDMI_TAIL;
						cnt_d = edmi_pkg::EDMI_TAIL_LAST;
					end
				end
			end
			edmi_pkg::EDMI_HOLD: begin
				if (cnt_q == edmi_pkg::EDMI_CNT_ZERO) begin
					state_d = edmi_pkg::EDMI_TAIL;
					cnt_d = edmi_pkg::EDMI_TAIL_LAST;
				end
			end
			edmi_pkg::EDMI_TAIL: begin
				// start cycle plus three tail cycles make the fixed overhead
				if (cnt_q == edmi_pkg::EDMI_CNT_ZERO) begin
					state_d = edmi_pkg::EDMI_IDLE;
				end
			end
			default: begin
				state_d = edmi_pkg::EDMI_IDLE;
				cnt_d = edmi_pkg::EDMI_CNT_ZERO;
			end
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			state_q <= edmi_pkg::EDMI_IDLE;
			cnt_q <= edmi_pkg::EDMI_CNT_ZERO;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	// ----------------------------------------------------------------
	// on-chip xram
	// ----------------------------------------------------------------
	edmi_xram u_xram (
		.clk(CLK_SYS),
		.rst_n(RESETN),
		.en(accept && onchip),
		.we(ACC_WRITE),
		.addr(eff[edmi_pkg::EDMI_XRAM_AW-1:0]),
		.wdata(ACC_WDATA),
		.rdata_q(ram_rdata)
	);

	// ----------------------------------------------------------------
	// read data path
	// ----------------------------------------------------------------
	// data pins pass two flops (sync3 unused) before capture; capture lags the strobe by two edges
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			sync1_v_q <= 8'h00;
			sync2_q <= 8'h00;
			sync3_q <= 8'h00;
		end else begin
			sync1_v_q <= EXT_DATA_I;
			sync2_q <= sync1_v_q;
			sync3_q <= sync2_q;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			rd_pipe_q <= 2'b00;
		end else begin
			rd_pipe_q <= {rd_pipe_q[0], (state_q == edmi_pkg::EDMI_STRB) &&
				(state_d != edmi_pkg::EDMI_STRB) && !req_q.write};
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			rdata_q <= 8'h00;
		end else if (state_q == edmi_pkg::EDMI_INT && !req_q.write) begin
			rdata_q <= ram_rdata;
		end else if (rd_pipe_q[edmi_pkg::EDMI_SYNC_CAPTURE]) begin
			// a single strobe-end sample: no time to wait for agreement
			rdata_q <= sync2_q;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			done_q <= 1'b0;
		end else begin
			done_q <= (state_q != edmi_pkg::EDMI_IDLE) &&
				(state_d == edmi_pkg::EDMI_IDLE);
		end
	end

	assign ACC_DONE = done_q;
	assign ACC_RDATA = rdata_q;
	assign ACC_BUSY = (state_q != edmi_pkg::EDMI_IDLE);

	// ----------------------------------------------------------------
	// pin drive
	// ----------------------------------------------------------------
	logic claim;
	logic in_ale;
	logic data_phase;

	assign claim = (state_q != edmi_pkg::EDMI_IDLE) &&
		(state_q != edmi_pkg::EDMI_INT);
	assign in_ale = (state_q == edmi_pkg::EDMI_ALEH) ||
		(state_q == edmi_pkg::EDMI_ALEL);
	assign data_phase = (state_q == edmi_pkg::EDMI_SETUP) ||
		(state_q == edmi_pkg::EDMI_STRB) || (state_q == edmi_pkg::EDMI_HOLD);

	assign PIN_CLAIM = claim;
	assign PORT_EN = cfg_now.port_en;
	assign EXT_ADDR_O = addr_q;
	assign EXT_ADDR_HI_OE = claim && hi_oe_q;
	// multiplexed low address rides the data lines instead
	assign EXT_ADDR_LO_OE = claim && cfg_q.mux_sel;
	assign EXT_ALE = (state_q == edmi_pkg::EDMI_ALEH);
	assign EXT_DATA_O = in_ale ? addr_q[7:0] : req_q.wdata;
	assign EXT_DATA_OE = (claim && !cfg_q.mux_sel && in_ale) ||
		(data_phase && req_q.write);
	assign EXT_RD_N = !((state_q == edmi_pkg::EDMI_STRB) && !req_q.write);
	assign EXT_WR_N = !((state_q == edmi_pkg::EDMI_STRB) && req_q.write);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic [5:0] claim_len_q;
	logic [4:0] strb_len_q;

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			claim_len_q <= 6'h00;
			strb_len_q <= 5'h00;
		end else begin
			claim_len_q <= claim ? claim_len_q + 6'h01 : 6'h00;
			strb_len_q <= (state_q == edmi_pkg::EDMI_STRB) ?
				strb_len_q + 5'h01 : 5'h00;
		end
	end

	a_internal_no_ext: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		accept && cfg_now.mode == edmi_pkg::EDMI_MODE_INT |=> !claim[*2])
		else $error("internal-only access claimed pins");

	a_external_claims: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		accept && cfg_now.mode == edmi_pkg::EDMI_MODE_EXT |=> claim)
		else $error("external-only access stayed on-chip");

	a_access_length: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		claim && !$past(claim) |-> ##[5:60] (!claim && claim_len_q ==
			6'(tim_q.setup + tim_q.width + tim_q.hold + 5 +
			(cfg_q.mux_sel ? 0 : 2 * (cfg_q.ale_w + 1)))))
		else $error("off-chip access length wrong");

	a_strobe_width: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		$fell(state_q == edmi_pkg::EDMI_STRB) |->
			strb_len_q == 5'(tim_q.width + 1))
		else $error("strobe width wrong");

	a_hi_undriven: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		claim && !req_q.wide && cfg_q.mode != edmi_pkg::EDMI_MODE_BANK
		|-> !EXT_ADDR_HI_OE)
		else $error("upper address driven on short form");

	a_bank_high: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		accept && !ACC_WIDE && cfg_now.mode == edmi_pkg::EDMI_MODE_BANK &&
		!onchip |=> EXT_ADDR_HI_OE && EXT_ADDR_O[15:8] == $past(page_q))
		else $error("bank select upper byte wrong");

	a_ale_address: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		EXT_ALE |-> EXT_DATA_OE && EXT_DATA_O == addr_q[7:0] && !EXT_ADDR_LO_OE)
		else $error("latch phase without low address");

	a_read_release: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		!EXT_RD_N |-> !EXT_DATA_OE && EXT_WR_N)
		else $error("data driven during read strobe");

	a_pins_return: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		$fell(claim) |-> ACC_DONE && !EXT_DATA_OE && !EXT_ADDR_HI_OE &&
			!EXT_ADDR_LO_OE && !EXT_ALE && EXT_RD_N && EXT_WR_N)
		else $error("pins not returned after access");

endmodule

/* verif/edmi_sram_model.sv */
// Purpose: behavioural external sram as seen through the memory pins
// Assumes: testbench resolves the shared data lines
// Notes:   released lines show the inverse of the last read value

module edmi_sram_model (
	// clock
	input wire logic clk,
	// pins from the interface
	input wire logic [15:0] addr_o,
	input wire logic hi_oe,
	input wire logic lo_oe,
	input wire logic [7:0] port_hi,
	input wire logic [7:0] dq,
	input wire logic ale,
	input wire logic rd_n,
	input wire logic wr_n,
	// data driven by the memory
	output logic [7:0] dq_drv
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [0:65535];
	logic [7:0] latch_q = 8'h00;
	logic [7:0] last_q = 8'h00;
	logic [15:0] a;

	// ----------------------------------------------------------------
	// address and data
	// ----------------------------------------------------------------
	// undriven upper lines fall back to the parked port value
	assign a = {hi_oe ? addr_o[15:8] : port_hi,
		lo_oe ? addr_o[7:0] : latch_q};
	// sampling mid-cycle keeps clear of strobe edges
	always @(negedge clk) begin
		if (ale)
			latch_q <= dq;
		if (!wr_n)
			mem[a] <= dq;
		if (!rd_n)
			last_q <= mem[a];
	end
	assign dq_drv = !rd_n ? mem[a] : ~last_q;
endmodule

/* verif/edmi_top_test.sv */
// Purpose: self-checking bench for the external data memory interface
// Assumes: sram model on the far side, upper port parked at 0xc0
// Notes:   timing register is left at zero for the routing scenarios

module edmi_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLK_SYS = 1'b0;
	logic RESETN = 1'b0;
	logic REG_WR = 1'b0;
	logic REG_RD = 1'b0;
	logic ACC_REQ = 1'b0;
	logic ACC_WIDE = 1'b0;
	logic ACC_WRITE = 1'b0;
	logic [7:0] REG_ADDR = 8'h00;
	logic [7:0] REG_WDATA = 8'h00;
	logic [7:0] ACC_IDX = 8'h00;
	logic [7:0] ACC_WDATA = 8'h00;
	logic [15:0] ACC_PTR = 16'h0000;
	logic [7:0] REG_RDATA, ACC_RDATA, EXT_DATA_O, EXT_DATA_I, sram_dq;
	logic [15:0] EXT_ADDR_O;
	logic ACC_BUSY, ACC_DONE, PIN_CLAIM, PORT_EN, EXT_ADDR_HI_OE;
	logic EXT_ADDR_LO_OE, EXT_DATA_OE, EXT_ALE, EXT_RD_N, EXT_WR_N;
	logic [7:0] port_hi = 8'hc0;
	int failures = 0;
	int cmp_count = 0;

	always #5 CLK_SYS = ~CLK_SYS;
	assign EXT_DATA_I = EXT_DATA_OE ? EXT_DATA_O : sram_dq;

	edmi_top dut (.CLK_SYS(CLK_SYS), .RESETN(RESETN),
		.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
		.REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .ACC_REQ(ACC_REQ),
		.ACC_WIDE(ACC_WIDE), .ACC_WRITE(ACC_WRITE), .ACC_PTR(ACC_PTR),
		.ACC_IDX(ACC_IDX), .ACC_WDATA(ACC_WDATA), .ACC_BUSY(ACC_BUSY),
		.ACC_DONE(ACC_DONE), .ACC_RDATA(ACC_RDATA), .PIN_CLAIM(PIN_CLAIM),
		.PORT_EN(PORT_EN), .EXT_ADDR_O(EXT_ADDR_O),
		.EXT_ADDR_HI_OE(EXT_ADDR_HI_OE), .EXT_ADDR_LO_OE(EXT_ADDR_LO_OE),
		.EXT_DATA_I(EXT_DATA_I), .EXT_DATA_O(EXT_DATA_O),
		.EXT_DATA_OE(EXT_DATA_OE), .EXT_ALE(EXT_ALE),
		.EXT_RD_N(EXT_RD_N), .EXT_WR_N(EXT_WR_N));

	edmi_sram_model sram (.clk(CLK_SYS), .addr_o(EXT_ADDR_O),
		.hi_oe(EXT_ADDR_HI_OE), .lo_oe(EXT_ADDR_LO_OE), .port_hi(port_hi),
		.dq(EXT_DATA_I), .ale(EXT_ALE), .rd_n(EXT_RD_N), .wr_n(EXT_WR_N),
		.dq_drv(sram_dq));

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task check(input string name, input logic [15:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task final_report;
		$display("checks %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task reg_wr(input logic [7:0] a, d);
		@(posedge CLK_SYS);
		REG_WR <= 1'b1;
		REG_ADDR <= a;
		REG_WDATA <= d;
		@(posedge CLK_SYS);
		REG_WR <= 1'b0;
	endtask

	task reg_chk(input logic [7:0] a, exp);
		@(posedge CLK_SYS);
		REG_RD <= 1'b1;
		REG_ADDR <= a;
		@(posedge CLK_SYS);
		REG_RD <= 1'b0;
		#1;
		check("register", {8'h00, REG_RDATA}, {8'h00, exp});
	endtask

	// one access; checks its length, pin claim and latch strobe cycles
	task xfer(input logic w, wr, input logic [15:0] p,
			input logic [7:0] i, d, input int en, ecl, eal,
			output logic [7:0] rd);
		int n, cl, al;
		@(posedge CLK_SYS);
		ACC_REQ <= 1'b1;
		ACC_WIDE <= w;
		ACC_WRITE <= wr;
		ACC_PTR <= p;
		ACC_IDX <= i;
		ACC_WDATA <= d;
		n = 0;
		cl = 0;
		al = 0;
		do begin
			@(posedge CLK_SYS);
			ACC_REQ <= 1'b0;
			#1;
			n++;
			if (n == 1)
				check("busy", {15'h0000, ACC_BUSY}, 16'h0001);
			if (PIN_CLAIM === 1'b1)
				cl++;
			if (EXT_ALE === 1'b1)
				al++;
		end while (ACC_DONE !== 1'b1 && n < 200);
		if (n >= 200) begin
			failures++;
			final_report();
		end
		rd = ACC_RDATA;
		check("cycles", n[15:0], en[15:0]);
		check("claim", cl[15:0], ecl[15:0]);
		check("latch", al[15:0], eal[15:0]);
		check("released", {15'h0000, PIN_CLAIM}, 16'h0000);
		check("idle", {15'h0000, ACC_BUSY}, 16'h0000);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task t_regs;
		reg_chk(edmi_pkg::EDMI_ADDR_TIMING, 8'hff);
		reg_chk(edmi_pkg::EDMI_ADDR_PAGE, 8'h00);
		reg_chk(edmi_pkg::EDMI_ADDR_CONFIG, 8'h03);
		reg_chk(8'hb0, 8'h00);
		reg_chk(edmi_pkg::EDMI_ADDR_STATUS, 8'h00);
		check("port off", {15'h0000, PORT_EN}, 16'h0000);
		reg_wr(edmi_pkg::EDMI_ADDR_TIMING, 8'h49);
		reg_chk(edmi_pkg::EDMI_ADDR_TIMING, 8'h49);
		reg_wr(edmi_pkg::EDMI_ADDR_TIMING, 8'h00);
	endtask

	task t_mux;
		logic [7:0] v;
		reg_wr(edmi_pkg::EDMI_ADDR_CONFIG, 8'h2c);
		xfer(1'b1, 1'b1, 16'h5011, 8'h00, 8'h3c, 8, 7, 1, v);
		check("port on", {15'h0000, PORT_EN}, 16'h0001);
		check("mux write", {8'h00, sram.mem[16'h5011]}, 16'h003c);
		reg_wr(edmi_pkg::EDMI_ADDR_CONFIG, 8'h2f);
		xfer(1'b1, 1'b0, 16'h5011, 8'h00, 8'h00, 14, 13, 4, v);
		check("mux read", {8'h00, v}, 16'h003c);
	endtask

	task t_internal;
		logic [7:0] v;
		reg_wr(edmi_pkg::EDMI_ADDR_CONFIG, 8'h30);
		xfer(1'b1, 1'b1, 16'h1005, 8'h00, 8'h77, 2, 0, 0, v);
		xfer(1'b1, 1'b0, 16'h2005, 8'h00, 8'h00, 2, 0, 0, v);
		check("alias", {8'h00, v}, 16'h0077);
		reg_wr(edmi_pkg::EDMI_ADDR_PAGE, 8'h30);
		xfer(1'b0, 1'b0, 16'h0000, 8'h05, 8'h00, 2, 0, 0, v);
		check("short", {8'h00, v}, 16'h0077);
	endtask

	task t_split;
		logic [7:0] v;
		reg_wr(edmi_pkg::EDMI_ADDR_CONFIG, 8'h34);
		reg_wr(edmi_pkg::EDMI_ADDR_PAGE, 8'h00);
		xfer(1'b0, 1'b0, 16'h0000, 8'h05, 8'h00, 2, 0, 0, v);
		check("page on", {8'h00, v}, 16'h0077);
		xfer(1'b1, 1'b1, 16'h1000, 8'h00, 8'h44, 6, 5, 0, v);
		check("edge", {8'h00, sram.mem[16'h1000]}, 16'h0044);
		xfer(1'b1, 1'b1, 16'h2345, 8'h00, 8'h11, 6, 5, 0, v);
		check("wide", {8'h00, sram.mem[16'h2345]}, 16'h0011);
		reg_wr(edmi_pkg::EDMI_ADDR_PAGE, 8'h30);
		xfer(1'b0, 1'b1, 16'h0000, 8'h66, 8'h22, 6, 5, 0, v);
		check("nobank", {8'h00, sram.mem[16'hc066]}, 16'h0022);
	endtask

	task t_bank_ext;
		logic [7:0] v;
		reg_wr(edmi_pkg::EDMI_ADDR_CONFIG, 8'h38);
		xfer(1'b0, 1'b1, 16'h0000, 8'h66, 8'h55, 6, 5, 0, v);
		check("bank", {8'h00, sram.mem[16'h3066]}, 16'h0055);
		reg_wr(edmi_pkg::EDMI_ADDR_CONFIG, 8'h3c);
		xfer(1'b1, 1'b1, 16'h0005, 8'h00, 8'h66, 6, 5, 0, v);
		check("ext", {8'h00, sram.mem[16'h0005]}, 16'h0066);
		xfer(1'b0, 1'b0, 16'h0000, 8'h66, 8'h00, 6, 5, 0, v);
		check("ext short", {8'h00, v}, 16'h0022);
		reg_wr(edmi_pkg::EDMI_ADDR_CONFIG, 8'h30);
		xfer(1'b1, 1'b0, 16'h0005, 8'h00, 8'h00, 2, 0, 0, v);
		check("hidden", {8'h00, v}, 16'h0077);
	endtask

	task t_timing;
		logic [7:0] v;
		logic [7:0] tv [3] = '{8'h00, 8'h49, 8'hff};
		int en [3] = '{5, 9, 26};
		reg_wr(edmi_pkg::EDMI_ADDR_CONFIG, 8'h3c);
		for (int k = 0; k < 3; k++) begin
			reg_wr(edmi_pkg::EDMI_ADDR_TIMING, tv[k]);
			xfer(1'b1, 1'b1, 16'h4000, 8'h00, 8'ha0 + 8'(k),
				en[k] + 1, en[k], 0, v);
			xfer(1'b1, 1'b0, 16'h4000, 8'h00, 8'h00,
				en[k] + 1, en[k], 0, v);
			check("timed", {8'h00, v}, {8'h00, 8'ha0 + 8'(k)});
		end
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (2) @(posedge CLK_SYS);
		RESETN <= 1'b1;
		t_regs();
		t_mux();
		t_internal();
		t_split();
		t_bank_ext();
		t_timing();
		final_report();
	end
endmodule
